// ==== inc/csp_pkg.sv ====
// constants and types for the codec serial port pin logic
// Overview of operation
// - The port counts as busy while frame_sync_n is low and stays busy until the next bit clock fall after it rises.
// - frame_sync_n stays low for every bit of a transfer and rises only after the last bit.
// - The serial data output is released (enable low) whenever frame_sync_n is high.
// - Converter result bits leave on the serial data output in step with the bit clock.
// - The host drives sample and command bits on the data input in step with the bit clock; the device captures them on the same clock.
// - On a primary transfer function_ctrl is sampled and held on the bit clock rise of the last bit, one master clock before frame_sync_n rises.
// - In phone mode the alternate_input pin replaces the device output during secondary transfers.
// - In phone mode each flag pin shows its bit of the second control register.
// - Every internal timing enable is derived from the master clock.
`default_nettype none
package csp_pkg;
  localparam int CSP_WORD_BITS = 16;
  localparam int CSP_PIN_LANES = 4;
  localparam int CSP_LANE_SCLK = 3;
  localparam int CSP_LANE_DIN  = 2;
  localparam int CSP_LANE_FC   = 1;
  localparam int CSP_LANE_ALT  = 0;
  localparam int CSP_FLAG_BITS = 2;
  localparam logic CSP_FLAG_IDLE = 1'b0;
  typedef enum logic [1:0] {
    CSP_IDLE,
    CSP_SHIFT,
    CSP_DONE
  } csp_state_t;
endpackage : csp_pkg
`default_nettype wire

// ==== core/csp_sync.sv ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module csp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule : csp_sync
`default_nettype wire

// ==== core/csp_port.sv ====
// codec serial port: frame sync, data shift, phone mode pass-through
`timescale 1ns/1ns
`default_nettype none
module csp_port
  import csp_pkg::*;
#(
  parameter int WORD_BITS = CSP_WORD_BITS
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     sclk_i,
  input  wire logic                     din_i,
  input  wire logic                     function_ctrl_i,
  input  wire logic                     alternate_input_i,
  input  wire logic                     start_i,
  input  wire logic                     secondary_i,
  input  wire logic [WORD_BITS-1:0]     adc_word_i,
  input  wire logic                     phone_mode_i,
  input  wire logic [CSP_FLAG_BITS-1:0] ctrl2_flags_i,
  output logic                          frame_sync_n_o,
  output logic                          dout_o,
  output logic                          dout_oe_o,
  output logic [CSP_FLAG_BITS-1:0]      flag_o,
  output logic [WORD_BITS-1:0]          rx_word_o,
  output logic                          rx_valid_o,
  output logic                          rx_secondary_o,
  output logic                          function_ctrl_o,
  output logic                          busy_o
);
  localparam int CW = $clog2(WORD_BITS + 1);
  localparam logic [CW-1:0] LAST = CW'(WORD_BITS - 1);

  logic [CSP_PIN_LANES-1:0] pin_raw;
  logic [CSP_PIN_LANES-1:0] pin_s;
  logic                 sclk_s;
  logic                 din_s;
  logic                 fc_s;
  logic                 alt_s;
  logic                 sclk_prev_q;
  logic                 rise;
  logic                 fall;
  csp_state_t           state_q;
  logic [CW-1:0]        cnt_q;
  logic [WORD_BITS-1:0] tx_q;
  logic [WORD_BITS-1:0] rx_q;
  logic                 sec_q;
  logic                 alt_out;
  logic                 dout_d;
  logic [CSP_FLAG_BITS-1:0] flag_d;
  logic                 frame_take;
  logic                 final_rise;

  // frame opens on a synced bit clock fall while idle with a request
  function automatic logic is_take(input csp_state_t st,
                                   input logic       req,
                                   input logic       sclk_fall);
    return (st == CSP_IDLE) && req && sclk_fall;
  endfunction : is_take

  // rise that captures the last bit of a frame
  function automatic logic is_final(input csp_state_t    st,
                                    input logic [CW-1:0] cnt,
                                    input logic          sclk_rise);
    return (st == CSP_SHIFT) && sclk_rise && (cnt == LAST);
  endfunction : is_final

  assign frame_take = is_take(state_q, start_i, fall);
  assign final_rise = is_final(state_q, cnt_q, rise);

  // all pins from outside the clock domain pass two flip-flops
  assign pin_raw[CSP_LANE_SCLK] = sclk_i;
  assign pin_raw[CSP_LANE_DIN]  = din_i;
  assign pin_raw[CSP_LANE_FC]   = function_ctrl_i;
  assign pin_raw[CSP_LANE_ALT]  = alternate_input_i;

  csp_sync #(.W(CSP_PIN_LANES)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (pin_raw),
    .q_o   (pin_s)
  );
  assign sclk_s = pin_s[CSP_LANE_SCLK];
  assign din_s  = pin_s[CSP_LANE_DIN];
  assign fc_s   = pin_s[CSP_LANE_FC];
  assign alt_s  = pin_s[CSP_LANE_ALT];

  // bit clock edges found with the master clock
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
    end
  end
  assign rise = sclk_s & ~sclk_prev_q;
  assign fall = ~sclk_s & sclk_prev_q;

  // frame sequencer
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= CSP_IDLE;
      cnt_q   <= '0;
      sec_q   <= 1'b0;
    end else begin
      case (state_q)
        CSP_IDLE: begin
          if (frame_take) begin
            state_q <= CSP_SHIFT;
            cnt_q   <= '0;
            sec_q   <= secondary_i;
          end
        end
        CSP_SHIFT: begin
          if (rise) begin
            if (cnt_q == LAST) begin
              state_q <= CSP_DONE;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
        end
        CSP_DONE: begin
          if (fall) begin
            state_q <= CSP_IDLE;
          end
        end
        default: state_q <= CSP_IDLE;
      endcase
    end
  end

  // frame sync low for the whole transfer
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      frame_sync_n_o <= 1'b1;
      busy_o         <= 1'b0;
    end else begin
      frame_sync_n_o <= (state_q != CSP_SHIFT);
      busy_o         <= (state_q != CSP_IDLE);
    end
  end

  // transmit shift on falling bit clock, receive on rising
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_q <= '0;
    end else if (frame_take) begin
      tx_q <= adc_word_i;
    end else if (state_q == CSP_SHIFT && fall) begin
      tx_q <= {tx_q[WORD_BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_q <= '0;
    end else if (state_q == CSP_SHIFT && rise) begin
      rx_q <= {rx_q[WORD_BITS-2:0], din_s};
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_word_o      <= '0;
      rx_valid_o     <= 1'b0;
      rx_secondary_o <= 1'b0;
    end else begin
      rx_valid_o <= 1'b0;
      if (final_rise) begin
        rx_word_o      <= {rx_q[WORD_BITS-2:0], din_s};
        rx_valid_o     <= 1'b1;
        rx_secondary_o <= sec_q;
      end
    end
  end

  // function control latched on the last bit clock rise of a primary transfer, one clock before frame sync rises
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      function_ctrl_o <= 1'b0;
    end else if (final_rise && !sec_q) begin
      function_ctrl_o <= fc_s;
    end
  end

  // data output, tristate outside frame, phone pass-through
  assign alt_out = phone_mode_i & sec_q;
  always_comb begin
    dout_d = tx_q[WORD_BITS-1];
    if (alt_out) begin
      dout_d = alt_s;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dout_o    <= 1'b0;
      dout_oe_o <= 1'b0;
    end else begin
      dout_oe_o <= (state_q == CSP_SHIFT);
      dout_o    <= dout_d;
    end
  end

  // flag pins: control bit in phone mode, idle level otherwise
  for (genvar g = 0; g < CSP_FLAG_BITS; g++) begin : g_flag
    assign flag_d[g] = phone_mode_i ? ctrl2_flags_i[g]
                                    : CSP_FLAG_IDLE;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_o <= {CSP_FLAG_BITS{CSP_FLAG_IDLE}};
    end else begin
      flag_o <= flag_d;
    end
  end
endmodule : csp_port
`default_nettype wire

// ==== tb/csp_port_assertions.sv ====
// checker for the codec serial port pins
`timescale 1ns/1ns
`default_nettype none
module csp_port_assertions (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       sclk_i,
  input wire logic       phone_mode_i,
  input wire logic [1:0] ctrl2_flags_i,
  input wire logic       frame_sync_n_o,
  input wire logic       dout_o,
  input wire logic       dout_oe_o,
  input wire logic [1:0] flag_o,
  input wire logic       rx_valid_o,
  input wire logic       function_ctrl_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_off; frame_sync_n_o |-> !dout_oe_o; endproperty
  a_off: assert property (p_off) else $error("idle drive");
  property p_act; $fell(frame_sync_n_o) |-> dout_oe_o; endproperty
  a_act: assert property (p_act) else $error("no drive");
  property p_len; $fell(frame_sync_n_o) |-> !frame_sync_n_o[*8]; endproperty
  a_len: assert property (p_len) else $error("short");
  property p_end;
    $rose(frame_sync_n_o) |-> ##[0:1] rx_valid_o || $past(rx_valid_o);
  endproperty
  a_end: assert property (p_end) else $error("no word");
  property p_fc;
    $changed(function_ctrl_o) |->
      $rose(frame_sync_n_o) || !$past(frame_sync_n_o, 2);
  endproperty
  a_fc: assert property (p_fc) else $error("fc moved");
  property p_flg0; !$past(phone_mode_i) |-> flag_o == 2'h0; endproperty
  a_flg0: assert property (p_flg0) else $error("flag on");
  property p_flg1;
    $past(phone_mode_i) |-> flag_o == $past(ctrl2_flags_i);
  endproperty
  a_flg1: assert property (p_flg1) else $error("flag");
  property p_dout;
    dout_oe_o && $past(dout_oe_o) && !phone_mode_i && $changed(dout_o)
      |-> !$past(sclk_i, 2);
  endproperty
  a_dout: assert property (p_dout) else $error("dout");
endmodule : csp_port_assertions
bind csp_port csp_port_assertions i_chk (.*);
`default_nettype wire

// ==== tb/csp_host.sv ====
// host port model: bit clock and data
`timescale 1ns/1ns
`default_nettype none
module csp_host (
  output logic      sclk_o,
  output logic      din_o,
  input  wire logic dout_i
);
  initial begin
    sclk_o = 1'b1;
    din_o = 1'b0;
  end
  task automatic tick;
    sclk_o = 1'b0;
    #40 sclk_o = 1'b1;
    #40;
  endtask : tick
  task automatic frame(input logic [15:0] w, output logic [15:0] r);
    for (int i = 15; i >= 0; i--) begin
      sclk_o = 1'b0;
      din_o = w[i];
      #40 sclk_o = 1'b1;
      #14 r[i] = dout_i;
      #26;
    end
    din_o = ~din_o;
  endtask : frame
endmodule : csp_host
`default_nettype wire

// ==== tb/tb.sv ====
// bench for the codec serial port pins
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        clk_i = 1'b0, rst_i = 1'b1, function_ctrl_i = 1'b0;
  logic        alternate_input_i = 1'b1, start_i = 1'b0;
  logic        secondary_i = 1'b0, phone_mode_i = 1'b0;
  logic [15:0] adc_word_i = 16'h0, rx_word_o, a, h, e, got;
  logic [1:0]  ctrl2_flags_i = 2'h0, flag_o, z, f;
  logic        frame_sync_n_o, dout_o, dout_oe_o, rx_valid_o;
  logic        rx_secondary_o, function_ctrl_o, busy_o, s, p, c, x;
  wire         sclk_i, din_i;
  wire         dout_w = dout_oe_o ? dout_o : 1'bz;
  int          fails = 0, compares = 0;
  logic [55:0] rows [4] = '{56'ha5c3_3c5a_a5c3_0f, 56'h1234_8001_ffff_39,
                            56'h0ff0_7ffe_0ff0_25, 56'h8001_ffff_8001_14};
  csp_port i_dut (.*);
  csp_host i_host (.sclk_o(sclk_i), .din_o(din_i), .dout_i(dout_w));
  always #5 clk_i = ~clk_i;
  task chk(input logic [15:0] v, w);
    compares++;
    if (v !== w) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, v, w);
    end
  endtask : chk
  task finish_test;
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  initial begin
    #50000;
    fails++;
    finish_test();
  end
  initial begin
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    foreach (rows[i]) begin
      i_host.tick();
      @(negedge clk_i);
      {a, h, e, z, s, p, f, c, x} = rows[i];
      adc_word_i = a;
      secondary_i = s;
      phone_mode_i = p;
      ctrl2_flags_i = f;
      function_ctrl_i = c;
      start_i = 1'b1;
      i_host.frame(h, got);
      @(negedge clk_i);
      start_i = 1'b0;
      repeat (4) @(negedge clk_i);
      chk(rx_word_o, h);
      chk(got, e);
      chk(16'({function_ctrl_o, flag_o}), 16'({x, p ? f : 2'h0}));
      chk(16'({rx_secondary_o, busy_o}), 16'({s, 1'b1}));
    end
    i_host.tick();
    @(negedge clk_i);
    start_i = 1'b1;
    phone_mode_i = 1'b0;
    fork
      i_host.frame(16'h0, got);
      begin
        repeat (12) @(negedge clk_i);
        chk(16'({frame_sync_n_o, dout_oe_o}), 16'h1);
        rst_i = 1'b1;
        start_i = 1'b0;
        @(negedge clk_i);
        chk(16'({frame_sync_n_o, dout_oe_o, flag_o, busy_o}), 16'h10);
        rst_i = 1'b0;
      end
    join
    i_host.tick();
    @(negedge clk_i);
    adc_word_i = 16'h5a5a;
    secondary_i = 1'b1;
    phone_mode_i = 1'b1;
    alternate_input_i = 1'b0;
    start_i = 1'b1;
    i_host.frame(16'hc33c, got);
    @(negedge clk_i);
    start_i = 1'b0;
    repeat (4) @(negedge clk_i);
    chk(rx_word_o, 16'hc33c);
    chk(got, 16'h0);
    chk(16'({rx_secondary_o, function_ctrl_o, flag_o}), 16'h9);
    finish_test();
  end
endmodule : tb
`default_nettype wire
